// >>> common/plm_defs.svh
// Register map, field positions and timing counts of the dual modulator
`ifndef PLM_DEFS_SVH
`define PLM_DEFS_SVH

`define PLM_IDX_DUTY_A     8'h0a
`define PLM_IDX_DUTY_B     8'h0b
`define PLM_IDX_MISC       8'h0c
`define PLM_IDX_STATUS     8'h0d

`define PLM_DUTY_RESET     8'h00
`define PLM_MISC_RESET     8'h00

`define PLM_BIT_SLOW_A     3
`define PLM_BIT_SLOW_B     2
`define PLM_BIT_SYS_SLOW   1

`define PLM_BIT_ST_OUT_A   0
`define PLM_BIT_ST_OUT_B   1
`define PLM_BIT_ST_STOP    2

`define PLM_BUS_DIV_FAST   6'd2
`define PLM_BUS_DIV_SLOW   6'd32
`define PLM_TIMER_DIV      2'd3
`define PLM_FAST_STEPS     16'd256
`define PLM_SLOW_STEPS     16'd4096
`define PLM_SLOW_STEP_LEN  5'd16

`endif

// >>> common/plm_pkg.sv
// Types shared by the dual modulator design
package plm_pkg;
	typedef logic [7:0] duty_type;
	typedef logic [15:0] timer_type;
	typedef enum logic {
		RATE_FAST = 1'b0,
		RATE_SLOW = 1'b1
	} rate_type;
endpackage

// >>> hdl/plm_timebase.sv
// Bus clock divider, timer prescaler and shared timer counter
`timescale 1ns/1ps
`default_nettype none
`include "plm_defs.svh"

module plm_timebase
	import plm_pkg::*;
(
	input  wire logic      ref_clk,
	input  wire logic      rstSyncN,
	input  wire logic      systemSlow,
	input  wire logic      stopMode,
	input  wire logic      timerClear,
	output logic           busTick,
	output logic           timerTick,
	output logic           stepEvent,
	output timer_type      timerCount
);
	logic [4:0] divCnt_q;
	logic [1:0] preCnt_q;
	logic [4:0] divLimit;
	logic       clearNow;

	assign divLimit  = systemSlow ? 5'(`PLM_BUS_DIV_SLOW - 6'd1)
	                              : 5'(`PLM_BUS_DIV_FAST - 6'd1);
	assign busTick   = !stopMode && (divCnt_q >= divLimit);
	assign timerTick = busTick && (preCnt_q == `PLM_TIMER_DIV);
	assign clearNow  = !stopMode && timerClear;
	assign stepEvent = timerTick || clearNow;

	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			divCnt_q <= 5'd0;
			preCnt_q <= 2'd0;
		end else if (busTick) begin
			divCnt_q <= 5'd0;
			preCnt_q <= preCnt_q + 2'd1;
		end else if (!stopMode) begin
			divCnt_q <= divCnt_q + 5'd1;
		end
	end

	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			timerCount <= 16'h0000;
		end else if (clearNow) begin
			timerCount <= 16'h0000;
		end else if (timerTick) begin
			timerCount <= timerCount + 16'h0001;
		end
	end
endmodule
`default_nettype wire

// >>> hdl/plm_channel.sv
// One pulse length modulator channel with its active duty comparator
`timescale 1ns/1ps
`default_nettype none
`include "plm_defs.svh"

module plm_channel
	import plm_pkg::*;
(
	input  wire logic      ref_clk,
	input  wire logic      rstSyncN,
	input  wire logic      stepEvent,
	input  wire timer_type timerNext,
	input  wire rate_type  rate,
	input  wire duty_type  dutyBuffer,
	output logic           pinOut,
	output duty_type       activeDuty
);
	logic [7:0] stepIdx;
	logic       cycleStart;

	// Slow rate uses counter bits 11:4 so each step spans 16 timer periods
	assign stepIdx    = (rate == RATE_SLOW) ? timerNext[11:4]
	                                        : timerNext[7:0];
	assign cycleStart = (rate == RATE_SLOW) ? (timerNext[11:0] == 12'h000)
	                                        : (timerNext[7:0] == 8'h00);

	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			activeDuty <= `PLM_DUTY_RESET;
			pinOut     <= 1'b0;
		end else if (stepEvent) begin
			if (cycleStart) begin
				activeDuty <= dutyBuffer;
				pinOut     <= (dutyBuffer != 8'h00);
			end else begin
				pinOut <= (stepIdx < activeDuty);
			end
		end
	end
endmodule
`default_nettype wire

// >>> hdl/dual_pulse_length_dac.sv
// Dual pulse length modulator with APB registers and stop handling
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "plm_defs.svh"

module dual_pulse_length_dac
	import plm_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        stopMode,
	input  wire logic        timerClear,
	output logic             channelAOut,
	output logic             channelBOut,
	output logic             busTick,
	output logic             systemSlow
);
	function automatic logic [7:0] byteAddr(input logic [7:0] idx);
		byteAddr = {idx[5:0], 2'b00};
	endfunction

	function automatic logic [7:0] stepOf(input rate_type r,
	                                      input timer_type t);
		stepOf = (r == RATE_SLOW) ? t[11:4] : t[7:0];
	endfunction

	function automatic logic atStart(input rate_type r,
	                                 input timer_type t);
		atStart = (r == RATE_SLOW) ? (t[11:0] == 12'h000)
		                           : (t[7:0] == 8'h00);
	endfunction

	logic       rstMeta_q;
	logic       rstSyncN;
	duty_type   dutyA_q;
	duty_type   dutyB_q;
	logic       slowA_q;
	logic       slowB_q;
	logic       sysSlow_q;
	logic       stopSeen_q;
	logic [31:0] rdata_q;
	logic       err_q;
	logic       timerTick;
	logic       stepEvent;
	timer_type  timerCount;
	duty_type   activeA;
	duty_type   activeB;
	rate_type   rateA;
	rate_type   rateB;

	// Reset release through two flip-flops
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rstMeta_q <= 1'b0;
			rstSyncN  <= 1'b0;
		end else begin
			rstMeta_q <= 1'b1;
			rstSyncN  <= rstMeta_q;
		end
	end

	// Address decode
	logic       selDutyA;
	logic       selDutyB;
	logic       selMisc;
	logic       selStatus;
	logic       mapped;
	logic       setupPhase;
	logic       writeNow;
	logic       stopEntry;
	logic [7:0] miscRead;
	logic [7:0] statusRead;
	logic [7:0] readByte;

	assign selDutyA   = (paddr == byteAddr(`PLM_IDX_DUTY_A));
	assign selDutyB   = (paddr == byteAddr(`PLM_IDX_DUTY_B));
	assign selMisc    = (paddr == byteAddr(`PLM_IDX_MISC));
	assign selStatus  = (paddr == byteAddr(`PLM_IDX_STATUS));
	assign mapped     = selDutyA || selDutyB || selMisc || selStatus;
	assign setupPhase = psel && !penable;
	assign writeNow   = psel && penable && pwrite && mapped;
	assign stopEntry  = stopMode && !stopSeen_q;

	assign miscRead = {4'h0, slowA_q, slowB_q, sysSlow_q, 1'b0};
	assign statusRead = {5'h00, stopMode, channelBOut, channelAOut};
	assign readByte = selDutyA  ? dutyA_q  :
	                  selDutyB  ? dutyB_q  :
	                  selMisc   ? miscRead :
	                  selStatus ? statusRead : 8'h00;

	// Zero wait state: read data captured in the setup cycle
	assign pready  = 1'b1;
	assign prdata  = rdata_q;
	assign pslverr = err_q;

	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			rdata_q <= 32'h0000_0000;
			err_q   <= 1'b0;
		end else if (setupPhase) begin
			rdata_q <= pwrite ? 32'h0000_0000 : {24'h000000, readByte};
			err_q   <= !mapped;
		end
	end

	// Duty buffers written by software
	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			dutyA_q <= `PLM_DUTY_RESET;
			dutyB_q <= `PLM_DUTY_RESET;
		end else if (writeNow && selDutyA) begin
			dutyA_q <= pwdata[7:0];
		end else if (writeNow && selDutyB) begin
			dutyB_q <= pwdata[7:0];
		end
	end

	// Control bits; slow selects take effect at once, not buffered
	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			slowA_q   <= 1'(`PLM_MISC_RESET >> `PLM_BIT_SLOW_A);
			slowB_q   <= 1'b0;
			sysSlow_q <= 1'b0;
		end else if (stopEntry) begin
			sysSlow_q <= 1'b0;
		end else if (writeNow && selMisc) begin
			slowA_q   <= pwdata[`PLM_BIT_SLOW_A];
			slowB_q   <= pwdata[`PLM_BIT_SLOW_B];
			sysSlow_q <= pwdata[`PLM_BIT_SYS_SLOW];
		end
	end

	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			stopSeen_q <= 1'b0;
		end else begin
			stopSeen_q <= stopMode;
		end
	end

	assign systemSlow = sysSlow_q;
	assign rateA = slowA_q ? RATE_SLOW : RATE_FAST;
	assign rateB = slowB_q ? RATE_SLOW : RATE_FAST;

	// Shared timebase; stop freezes it, wait has no input here
	plm_timebase timebase (
		.ref_clk    (ref_clk),
		.rstSyncN   (rstSyncN),
		.systemSlow (sysSlow_q),
		.stopMode   (stopMode),
		.timerClear (timerClear),
		.busTick    (busTick),
		.timerTick  (timerTick),
		.stepEvent  (stepEvent),
		.timerCount (timerCount)
	);

	logic [15:0] nextCount;
	assign nextCount = timerClear ? 16'h0000 : timerCount + 16'h0001;

	// Both channels share the timer counter
	plm_channel channelA (
		.ref_clk    (ref_clk),
		.rstSyncN   (rstSyncN),
		.stepEvent  (stepEvent),
		.timerNext  (nextCount),
		.rate       (rateA),
		.dutyBuffer (dutyA_q),
		.pinOut     (channelAOut),
		.activeDuty (activeA)
	);

	plm_channel channelB (
		.ref_clk    (ref_clk),
		.rstSyncN   (rstSyncN),
		.stepEvent  (stepEvent),
		.timerNext  (nextCount),
		.rate       (rateB),
		.dutyBuffer (dutyB_q),
		.pinOut     (channelBOut),
		.activeDuty (activeB)
	);

	// Checks
	chk_duty_zero_low: assert property (
		@(posedge ref_clk) disable iff (!rstSyncN)
		$rose(channelAOut) |-> $past(dutyA_q) != 8'h00)
		else $error("channel A went high with zero duty");

	chk_cycle_start_a: assert property (
		@(posedge ref_clk) disable iff (!rstSyncN)
		$rose(channelAOut) |-> atStart(rateA, timerCount))
		else $error("channel A rose away from cycle start");

	chk_cycle_start_b: assert property (
		@(posedge ref_clk) disable iff (!rstSyncN)
		$rose(channelBOut) |-> atStart(rateB, timerCount))
		else $error("channel B rose away from cycle start");

	chk_timer_tick_spacing: assert property (
		@(posedge ref_clk) disable iff (!rstSyncN)
		timerTick && !sysSlow_q |=> !timerTick [*7])
		else $error("timer tick faster than four bus clocks");

	chk_duty_load_end: assert property (
		@(posedge ref_clk) disable iff (!rstSyncN)
		activeA != $past(activeA) |-> atStart(rateA, timerCount))
		else $error("duty loaded in mid cycle");

	chk_duty_reset_zero: assert property (
		@(posedge ref_clk)
		!rstSyncN |-> dutyA_q == 8'h00 && dutyB_q == 8'h00)
		else $error("duty not cleared by reset");

	chk_timer_clear_zero: assert property (
		@(posedge ref_clk) disable iff (!rstSyncN)
		timerClear && !stopMode |=> timerCount == 16'h0000)
		else $error("timer counter not cleared");

	chk_bus_fast_div: assert property (
		@(posedge ref_clk) disable iff (!rstSyncN)
		busTick && !sysSlow_q |=> !busTick)
		else $error("bus tick faster than divide by two");

	chk_bus_slow_div: assert property (
		@(posedge ref_clk) disable iff (!rstSyncN)
		busTick && sysSlow_q |=> !busTick [*8])
		else $error("slow bus tick too frequent");

	chk_slow_stop_clear: assert property (
		@(posedge ref_clk) disable iff (!rstSyncN)
		stopMode && !stopSeen_q |=> !sysSlow_q)
		else $error("system slow bit kept on stop entry");

	chk_stop_hold_out: assert property (
		@(posedge ref_clk) disable iff (!rstSyncN)
		stopMode |=> $stable(channelAOut) && $stable(channelBOut))
		else $error("output changed during stop");

	chk_fall_at_duty: assert property (
		@(posedge ref_clk) disable iff (!rstSyncN)
		$fell(channelAOut) && $stable(slowA_q)
		|-> stepOf(rateA, timerCount) == activeA)
		else $error("channel A fell away from duty step");

	chk_slow_step_len: assert property (
		@(posedge ref_clk) disable iff (!rstSyncN)
		$fell(channelBOut) && rateB == RATE_SLOW && $stable(slowB_q)
		|-> timerCount[3:0] == 4'h0)
		else $error("slow step not 16 timer periods");
endmodule
`default_nettype wire

// >>> testbench/plm_load.sv
// Load model on one modulator pin: measures high time, period and rises
`timescale 1ns/1ps
`default_nettype none

module plm_load (
	input  wire logic   ref_clk,
	input  wire logic   rstn,
	input  wire logic   pinIn,
	output logic [31:0] highLen,
	output logic [31:0] period,
	output logic [31:0] rises
);
	logic [31:0] sinceRise;
	logic        pinQ;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pinQ      <= 1'b0;
			sinceRise <= 32'h0;
			highLen   <= 32'h0;
			period    <= 32'h0;
			rises     <= 32'h0;
		end else begin
			pinQ      <= pinIn;
			sinceRise <= sinceRise + 32'h1;
			if (pinIn && !pinQ) begin
				period    <= sinceRise;
				sinceRise <= 32'h1;
				rises     <= rises + 32'h1;
			end
			if (!pinIn && pinQ)
				highLen <= sinceRise;
		end
	end
endmodule

`default_nettype wire

// >>> testbench/tb_dual_pulse_length_dac.sv
// Self-checking bench for the dual modulator
`timescale 1ns/1ps
`default_nettype none
`include "plm_defs.svh"

module tb_dual_pulse_length_dac
	import plm_pkg::*;
;
	localparam logic [7:0] addrA    = 8'(4 * `PLM_IDX_DUTY_A);
	localparam logic [7:0] addrB    = 8'(4 * `PLM_IDX_DUTY_B);
	localparam logic [7:0] addrMisc = 8'(4 * `PLM_IDX_MISC);
	localparam logic [7:0] addrStat = 8'(4 * `PLM_IDX_STATUS);
	logic        ref_clk, rstn, psel, penable, pwrite, stopMode, timerClear;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, d, hiA, hiB, perA, perB, riseA, riseB;
	logic        pready, pslverr, outA, outB, busTick, systemSlow, e;
	logic [1:0]  hold;
	int          nErrors, nCompared, g;

	dual_pulse_length_dac uut (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.stopMode(stopMode), .timerClear(timerClear), .channelAOut(outA),
		.channelBOut(outB), .busTick(busTick), .systemSlow(systemSlow));
	plm_load loadA (.ref_clk(ref_clk), .rstn(rstn), .pinIn(outA),
		.highLen(hiA), .period(perA), .rises(riseA));
	plm_load loadB (.ref_clk(ref_clk), .rstn(rstn), .pinIn(outB),
		.highLen(hiB), .period(perB), .rises(riseB));

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		nCompared++;
		if (seen !== exp) begin
			nErrors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic err);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		apb(1'b1, a, wd, d, e);
	endtask

	task automatic waitTo(input logic chanB, input logic [31:0] target);
		int k;
		for (k = 0; k < 70000 && (chanB ? riseB : riseA) < target; k++)
			@(posedge ref_clk);
	endtask

	task automatic tickGap(output int gap);
		int k;
		for (k = 0; k < 100 && busTick !== 1'b1; k++)
			@(posedge ref_clk);
		gap = 0;
		do begin
			@(posedge ref_clk);
			gap++;
		end while (busTick !== 1'b1 && gap < 100);
	endtask

	task automatic completeRun();
		$display("Compared %0d mismatches %0d", nCompared, nErrors);
		if (nErrors == 0 && nCompared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		repeat (95000) @(posedge ref_clk);
		nErrors++;
		completeRun();
	end

	initial begin
		{rstn, psel, penable, pwrite, stopMode, timerClear} = 6'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		repeat (12) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge ref_clk);
		apb(1'b0, addrA, 32'h0, d, e);
		check("dutyA reset", d, 32'h0);
		apb(1'b0, addrB, 32'h0, d, e);
		check("dutyB reset", d, 32'h0);
		apb(1'b0, addrMisc, 32'h0, d, e);
		check("misc reset", d, 32'h0);
		wr(8'h3c, 32'hff);
		apb(1'b0, 8'h3c, 32'h0, d, e);
		check("unmapped", {d[30:0], e}, 32'h1);
		wr(addrMisc, 32'h04);
		wr(addrB, 32'h10);
		apb(1'b0, addrB, 32'h0, d, e);
		check("dutyB readback", d, 32'h10);
		repeat (2100) @(posedge ref_clk);
		check("zero duty rises", riseA, 32'h0);
		wr(addrA, 32'h80);
		waitTo(1'b0, riseA + 2);
		repeat (1040) @(posedge ref_clk);
		check("half duty high", hiA, 32'd1024);
		check("fast period", perA, 32'd2048);
		waitTo(1'b0, riseA + 1);
		repeat (900) @(posedge ref_clk);
		wr(addrA, 32'h40);
		check("buffered pin", {31'h0, outA}, 32'h1);
		waitTo(1'b0, riseA + 2);
		repeat (600) @(posedge ref_clk);
		check("new duty high", hiA, 32'd512);
		wr(addrA, 32'hff);
		waitTo(1'b0, riseA + 2);
		repeat (2044) @(posedge ref_clk);
		check("full duty high", hiA, 32'd2040);
		waitTo(1'b1, 32'h2);
		repeat (2100) @(posedge ref_clk);
		check("slow high", hiB, 32'd2048);
		check("slow period", perB, 32'd32768);
		waitTo(1'b0, riseA + 1);
		repeat (800) @(posedge ref_clk);
		timerClear <= 1'b1;
		@(posedge ref_clk);
		timerClear <= 1'b0;
		waitTo(1'b0, riseA + 1);
		check("timer clear", {31'h0, hiA > 32'd2040}, 32'h1);
		wr(addrMisc, 32'h06);
		tickGap(g);
		tickGap(g);
		check("slow bus tick", g, 32'd32);
		stopMode <= 1'b1;
		repeat (3) @(posedge ref_clk);
		hold = {outB, outA};
		apb(1'b0, addrMisc, 32'h0, d, e);
		check("stop clears slow", d, 32'h04);
		check("slow pin", {31'h0, systemSlow}, 32'h0);
		apb(1'b0, addrStat, 32'h0, d, e);
		check("stop status", {31'h0, d[2]}, 32'h1);
		check("status pins", {30'h0, d[1:0]}, {30'h0, hold});
		repeat (3000) @(posedge ref_clk);
		check("stop hold", {30'h0, outB, outA}, {30'h0, hold});
		d = riseA;
		stopMode <= 1'b0;
		waitTo(1'b0, d + 1);
		check("stop resume", riseA, d + 1);
		tickGap(g);
		check("fast bus tick", g, 32'd2);
		completeRun();
	end
endmodule

`default_nettype wire
